/* File: rtl/trace_aux_port_transmitter.sv */
// Trace output port: packet packer, 16-frame transmit queue, frame serializer and control registers
// Function
// - Data pins meaningful only on non-idle frames
// - Fixed packets pack directly after previous bits
// - Variable packets zero-padded to frame boundary
// - Variable packets drop leading zero bits
// - Start shown as idle then body pattern
// - End shown as 0x then idle
// - Variable packet end shown as 00 then 01
// - Body pattern inside messages, idle between
// - Double rate halves clock, both edges sample
// - Low speed divides frame rate by divisor+1, or by 2 at divisor 0
// - Forwarded clock edge centred in frame for even periods and full-rate single rate
// - All messages pass a 16-frame queue
// - Overrun refuses inserts until queue drains
// - First message after overrun is error message
// - Sync requested after error when trace lost
// - Stall bits hold the source instead of losing
// - Flush queue on reset, disable, application reset
// - Tracing suspended until enable bit written one
// - Error message is type code 8 plus code
// - Error code chosen from lost categories
// - Pin enable, override and pin map select
module trace_aux_port_transmitter (
   input  wire logic                            clk,
   input  wire logic                            rst,
   input  wire logic [trace_aux_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [trace_aux_pkg::REG_W-1:0] reg_wdata,
   input  wire logic                            reg_wr,
   input  wire logic                            reg_rd,
   output logic      [trace_aux_pkg::REG_W-1:0] reg_rdata_r,
   input  wire logic                            pkt_valid,
   input  trace_aux_pkg::trace_packet_type      pkt_in,
   output logic                                 pkt_ready_r,
   output logic                                 cpu_stall_r,
   output logic                                 sync_request_r,
   output logic                                 trace_enable_r,
   output logic      [trace_aux_pkg::TM_W-1:0]  trace_mode_r,
   output trace_aux_pkg::aux_pins_type          aux_pins_r,
   output logic                                 msg_clock_o,
   output logic      [1:0]                      pin_config_r
);
   import trace_aux_pkg::*;

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic logic [3:0] src_onehot(input logic [1:0] src);
      src_onehot = 4'h1 << src;
   endfunction

   function automatic logic type_enabled(input logic [1:0] src, input logic [TM_W-1:0] mode);
      type_enabled = (src == SRC_WATCH) ? 1'b1 : mode[src];
   endfunction

   function automatic logic [31:0] packet_mask(input trace_packet_type p);
      packet_mask = (p.len >= LEN_MAX) ? p.data : (p.data & ((32'h1 << p.len) - 32'h1));
   endfunction

   function automatic logic [LEN_W-1:0] packet_bits(input trace_packet_type p);
      logic [31:0]      masked;
      logic [LEN_W-1:0] n;
      masked = packet_mask(p);
      n = (p.len == 6'h00) ? LEN_ONE : ((p.len > LEN_MAX) ? LEN_MAX : p.len);
      if (p.var_len) begin
         n = LEN_ONE;
         for (int i = 0; i < PKT_BITS; i++) begin
            if (masked[i]) begin
               n = LEN_W'(i + 1);
            end
         end
      end
      packet_bits = n;
   endfunction

   function automatic logic [4:0] error_code_packet_of(input logic [3:0] lost);
      logic [2:0] trace;
      trace = lost[2:0];
      if (lost[SRC_WATCH] && trace != 3'h0) begin
         error_code_packet_of = ERROR_CODE_PACKET_ALL;
      end else if (lost[SRC_WATCH]) begin
         error_code_packet_of = ERROR_CODE_PACKET_WATCH;
      end else if (trace == 3'h1) begin
         error_code_packet_of = ERROR_CODE_PACKET_OWN;
      end else if (trace == 3'h2) begin
         error_code_packet_of = ERROR_CODE_PACKET_PROG;
      end else if (trace == 3'h4) begin
         error_code_packet_of = ERROR_CODE_PACKET_DATA;
      end else begin
         error_code_packet_of = ERROR_CODE_PACKET_TRACE;
      end
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [REG_W-1:0]  port_ctrl_r;
   logic [REG_W-1:0]  debug_ctrl_r;
   queue_frame_type   queue_mem [QUEUE_DEPTH];
   logic [PTR_W-1:0]  wr_ptr_r;
   logic [PTR_W-1:0]  rd_ptr_r;
   logic [CNT_W-1:0]  q_count_r;
   logic [CNT_W-1:0]  msgs_in_q_r;

   // Packer state
   logic [ACC_W-1:0]  acc_r;
   logic [LEN_W-1:0]  acc_bits_r;
   logic              flush_pending_r;
   logic              end_var_r;
   logic              end_msg_r;

   // Overrun and error state
   logic              overrun_r;
   logic              discard_r;
   logic              close_pending_r;
   logic              mid_msg_r;
   logic              ext_mid_r;
   logic [3:0]        lost_r;
   logic [1:0]        msg_src_r;
   err_step_type      err_step_r;

   // Serializer and forwarded clock
   ser_state_type     ser_state_r;
   logic [4:0]        phase_r;
   logic              mclk_r;

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   wire               sel_ctrl    = reg_addr == OFS_PORT_CTRL;
   wire               sel_dc      = reg_addr == OFS_DEBUG_CTRL;
   wire               sel_st      = reg_addr == OFS_STATUS;
   wire               wr_ctrl     = reg_wr && sel_ctrl;
   wire               wr_dc       = reg_wr && sel_dc;
   wire               app_reset   = wr_dc && reg_wdata[DC_RES];
   wire               dbe_off     = wr_dc && !reg_wdata[DC_DBE] && debug_ctrl_r[DC_DBE];
   wire               flush       = app_reset || dbe_off;
   wire [REG_W-1:0]   port_ctrl_nxt  = wr_ctrl ? (reg_wdata & CTL_RW_MASK) : port_ctrl_r;
   // Mode bits are taken from the same write that sets the enable or requests the reset
   wire [REG_W-1:0]   debug_ctrl_nxt = wr_dc ? (reg_wdata & DC_STORE_MASK) : debug_ctrl_r;

   // Decoded control fields
   wire               dbe         = debug_ctrl_r[DC_DBE];
   wire [TM_W-1:0]    tmode       = debug_ctrl_r[DC_TM_LSB +: TM_W];
   wire [OVC_W-1:0]   overrun_stall_bits         = debug_ctrl_r[DC_OVC_LSB +: OVC_W];
   wire               low_speed   = port_ctrl_r[CTL_LOW_SPEED];
   wire               ddr         = port_ctrl_r[CTL_DDR];
   wire [CTL_DIV_W-1:0] div       = port_ctrl_r[CTL_DIV_LSB +: CTL_DIV_W];
   wire [1:0]         pin_cfg_nxt = port_ctrl_nxt[CTL_OVERRIDE] ? PIN_CFG_FORCED
                                    : port_ctrl_nxt[CTL_SEL_LSB +: 2];

   // Status is read only; the lost mask clears as the error code is fed
   wire [REG_W-1:0]   status_word = (REG_W'(q_count_r) << ST_CNT_LSB) | (REG_W'(overrun_r) << ST_OVR)
                                    | (REG_W'(lost_r) << ST_LOST_LSB) | (REG_W'(msgs_in_q_r) << ST_MSGS_LSB);
   wire [REG_W-1:0]   rdata_nxt   = !reg_rd ? '0 : sel_ctrl ? port_ctrl_r : sel_dc ? debug_ctrl_r
                                    : sel_st ? status_word : '0;

   // ---------------------------------------------------------------
   // Frame timing and forwarded clock
   // ---------------------------------------------------------------
   // Divisor zero still halves the rate
   wire [4:0]         period      = !low_speed ? PERIOD_FULL
                                    : (div == 4'h0) ? PERIOD_DIV0 : (5'(div) + PERIOD_FULL);
   wire [4:0]         half        = period >> 1;
   wire               frame_tick  = phase_r >= (period - PERIOD_FULL);
   wire [4:0]         phase_nxt   = frame_tick ? 5'h00 : (phase_r + PERIOD_FULL);
   // Edge placed at the middle phase; odd periods land half a cycle early, worst at full-rate double rate
   wire               mclk_nxt    = ddr ? ((phase_nxt == half) ? !mclk_r : mclk_r)
                                    : (phase_nxt >= half);
   // A frame per clock cannot be forwarded from a flop, so the inverted clock is sent instead
   wire               full_sdr    = !low_speed && !ddr;
   assign msg_clock_o = full_sdr ? !clk : mclk_r;

   // ---------------------------------------------------------------
   // Queue
   // ---------------------------------------------------------------
   wire               q_full      = q_count_r == Q_FULL_COUNT;
   wire               q_empty     = q_count_r == '0;
   queue_frame_type   head;
   assign head = queue_mem[rd_ptr_r];
   // A complete message must be queued before its first frame leaves, so a message never starves
   wire               pop         = frame_tick && !q_empty && !flush && (ser_state_r == SER_MSG
                                    || (msgs_in_q_r != '0 && aux_pins_r.mseo == MSEO_IDLE));

   // ---------------------------------------------------------------
   // Packer
   // ---------------------------------------------------------------
   wire               emit_last   = flush_pending_r && acc_bits_r <= FRAME_BITS;
   wire               emit_full   = acc_bits_r >= FRAME_BITS && !emit_last;
   wire               emit        = emit_full || emit_last;
   wire               packer_busy = emit;
   wire               ovf         = emit && q_full;
   wire               push_close  = close_pending_r && !q_full;
   wire               push_emit   = emit && !q_full && !close_pending_r;
   wire               push        = push_close || push_emit;
   queue_frame_type   emit_frame;
   queue_frame_type   push_frame;
   assign emit_frame = '{data: acc_r[FRAME_W-1:0], end_var: emit_last && end_var_r,
                         end_msg: emit_last && end_msg_r};
   // An overrun may cut a message already partly queued; a zero frame closes it
   assign push_frame = push_close ? '{data: '0, end_var: 1'b0, end_msg: 1'b1} : emit_frame;

   // Packet sources: external trace and the injected error message
   wire               take        = pkt_valid && pkt_ready_r;
   wire               type_on     = dbe && type_enabled(pkt_in.source, tmode);
   wire               ext_feed    = take && type_on && !overrun_r && !discard_r;
   wire               ext_lost    = take && type_on && (overrun_r || discard_r);
   wire               inj_tcode   = overrun_r && err_step_r == ERR_IDLE && !close_pending_r
                                    && q_empty && !packer_busy;
   wire               inj_code    = err_step_r == ERR_SEND_CODE && !packer_busy;
   wire               trace_lost  = lost_r[2:0] != 3'h0;
   trace_packet_type  err_tcode_pkt;
   trace_packet_type  err_code_pkt;
   trace_packet_type  feed_pkt;
   assign err_tcode_pkt = '{data: 32'(ERR_TCODE), len: TCODE_W, var_len: 1'b0, last: 1'b0,
                            source: SRC_OWN};
   assign err_code_pkt  = '{data: 32'(error_code_packet_of(lost_r)), len: ERROR_CODE_PACKET_W, var_len: 1'b0, last: 1'b1,
                            source: SRC_OWN};
   assign feed_pkt = inj_tcode ? err_tcode_pkt : inj_code ? err_code_pkt : pkt_in;

   wire               feed        = ext_feed || inj_tcode || inj_code;
   wire [LEN_W-1:0]   feed_bits   = packet_bits(feed_pkt);
   wire [ACC_W-1:0]   feed_shift  = ACC_W'({6'h00, packet_mask(feed_pkt)} << acc_bits_r);
   wire               clear       = flush || ovf;
   wire [ACC_W-1:0]   acc_nxt     = clear ? '0 : emit ? (acc_r >> FRAME_W) : feed ? (acc_r | feed_shift) : acc_r;
   // Upper bits of the final frame stay zero, which is the padding
   wire [LEN_W-1:0]   bits_nxt    = clear ? '0 : emit_last ? '0 : emit_full ? (acc_bits_r - FRAME_BITS)
                                    : feed ? (acc_bits_r + feed_bits) : acc_bits_r;
   wire               flushp_nxt  = clear ? 1'b0 : emit_last ? 1'b0
                                    : feed ? (feed_pkt.var_len || feed_pkt.last) : flush_pending_r;

   // ---------------------------------------------------------------
   // Queue bookkeeping and flow control
   // ---------------------------------------------------------------
   wire               push_end    = push && push_frame.end_msg;
   wire               pop_end     = pop && head.end_msg;
   wire [CNT_W-1:0]   q_count_nxt = flush ? '0 : (push && !pop) ? (q_count_r + 5'h01)
                                    : (!push && pop) ? (q_count_r - 5'h01) : q_count_r;
   wire [CNT_W-1:0]   msgs_nxt    = flush ? '0 : (push_end && !pop_end) ? (msgs_in_q_r + 5'h01)
                                    : (!push_end && pop_end) ? (msgs_in_q_r - 5'h01) : msgs_in_q_r;
   // Stall is judged on the packet now offered; a watchpoint burst may still exceed the reserve
   wire               stall_nxt   = dbe && overrun_stall_bits[pkt_in.source]
                                    && (Q_FULL_COUNT - q_count_nxt) < STALL_ROOM;
   wire               ready_nxt   = bits_nxt < FRAME_BITS && !flushp_nxt && !stall_nxt;

   wire [3:0]         lost_nxt    = flush ? 4'h0 : inj_code ? 4'h0
                                    : lost_r | (ovf ? src_onehot(msg_src_r) : 4'h0)
                                    | (ext_lost ? src_onehot(pkt_in.source) : 4'h0);
   wire               ext_mid_nxt = take ? !pkt_in.last : ext_mid_r;

   // ---------------------------------------------------------------
   // Serializer
   // ---------------------------------------------------------------
   wire [1:0]         frame_mseo  = head.end_var ? MSEO_VEND : MSEO_BODY;
   wire [1:0]         mseo_nxt    = flush ? MSEO_IDLE : pop ? frame_mseo
                                    : frame_tick ? MSEO_IDLE : aux_pins_r.mseo;
   wire [FRAME_W-1:0] data_nxt    = flush ? '0 : pop ? head.data
                                    : frame_tick ? '0 : aux_pins_r.data;

   // Serializer state follows the end mark of the popped frame
   wire               ser_nxt_msg = pop && !head.end_msg;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port_ctrl_r    <= CTL_RESET;
         debug_ctrl_r   <= DC_RESET;
         reg_rdata_r    <= '0;
         trace_enable_r <= 1'b0;
         trace_mode_r   <= '0;
         pin_config_r   <= '0;
      end else begin
         port_ctrl_r    <= port_ctrl_nxt;
         debug_ctrl_r   <= debug_ctrl_nxt;
         reg_rdata_r    <= rdata_nxt;
         trace_enable_r <= debug_ctrl_nxt[DC_DBE];
         trace_mode_r   <= debug_ctrl_nxt[DC_TM_LSB +: TM_W];
         pin_config_r   <= pin_cfg_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         queue_mem[wr_ptr_r] <= push_frame;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_r    <= '0;
         rd_ptr_r    <= '0;
         q_count_r   <= '0;
         msgs_in_q_r <= '0;
      end else begin
         wr_ptr_r    <= flush ? '0 : push ? (wr_ptr_r + 4'h1) : wr_ptr_r;
         rd_ptr_r    <= flush ? '0 : pop ? (rd_ptr_r + 4'h1) : rd_ptr_r;
         q_count_r   <= q_count_nxt;
         msgs_in_q_r <= msgs_nxt;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_r           <= '0;
         acc_bits_r      <= '0;
         flush_pending_r <= 1'b0;
         end_var_r       <= 1'b0;
         end_msg_r       <= 1'b0;
         msg_src_r       <= SRC_OWN;
      end else begin
         acc_r           <= acc_nxt;
         acc_bits_r      <= bits_nxt;
         flush_pending_r <= flushp_nxt;
         end_var_r       <= feed ? feed_pkt.var_len : end_var_r;
         end_msg_r       <= feed ? feed_pkt.last : end_msg_r;
         msg_src_r       <= feed ? feed_pkt.source : msg_src_r;
      end
   end

   // Overrun, discard and error sequencing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         overrun_r       <= 1'b0;
         discard_r       <= 1'b0;
         close_pending_r <= 1'b0;
         mid_msg_r       <= 1'b0;
         ext_mid_r       <= 1'b0;
         lost_r          <= 4'h0;
         err_step_r      <= ERR_IDLE;
      end else begin
         overrun_r       <= flush ? 1'b0 : ovf ? 1'b1 : inj_code ? 1'b0 : overrun_r;
         discard_r       <= flush ? 1'b0 : ovf ? ext_mid_nxt : (take && pkt_in.last) ? 1'b0 : discard_r;
         close_pending_r <= flush ? 1'b0 : ovf ? mid_msg_r : push_close ? 1'b0 : close_pending_r;
         mid_msg_r       <= flush ? 1'b0 : push ? !push_frame.end_msg : mid_msg_r;
         ext_mid_r       <= flush ? 1'b0 : ext_mid_nxt;
         lost_r          <= lost_nxt;
         err_step_r      <= flush ? ERR_IDLE : inj_tcode ? ERR_SEND_CODE : inj_code ? ERR_IDLE : err_step_r;
      end
   end

   // Flow control toward the trace sources
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pkt_ready_r    <= 1'b0;
         cpu_stall_r    <= 1'b0;
         sync_request_r <= 1'b0;
      end else begin
         pkt_ready_r    <= ready_nxt;
         cpu_stall_r    <= stall_nxt;
         sync_request_r <= inj_code && trace_lost && !flush;
      end
   end

   // Pins are registered so the tool never sees decode glitches
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ser_state_r <= SER_IDLE;
         phase_r     <= '0;
         mclk_r      <= 1'b0;
         aux_pins_r  <= '{data: '0, mseo: MSEO_IDLE, oe: 1'b0};
      end else begin
         ser_state_r <= flush ? SER_IDLE : ser_nxt_msg ? SER_MSG : pop ? SER_IDLE : ser_state_r;
         phase_r     <= phase_nxt;
         mclk_r      <= mclk_nxt;
         aux_pins_r  <= '{data: data_nxt, mseo: mseo_nxt, oe: port_ctrl_nxt[CTL_PIN_EN]};
      end
   end

endmodule

/* File: rtl/trace_aux_pkg.sv */
// Constants, field layouts and carrier types of the trace output port
package trace_aux_pkg;

   // ---------------------------------------------------------------
   // Register bus and offsets
   // ---------------------------------------------------------------
   localparam int          REG_W           = 32;
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  OFS_PORT_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_DEBUG_CTRL  = 8'h04;
   localparam logic [7:0]  OFS_STATUS      = 8'h08;

   // ---------------------------------------------------------------
   // Trace port control fields
   // ---------------------------------------------------------------
   localparam int          CTL_DIV_LSB     = 0;
   localparam int          CTL_DIV_W       = 4;
   localparam int          CTL_PIN_EN      = 8;
   localparam int          CTL_OVERRIDE    = 9;
   localparam int          CTL_DDR         = 10;
   localparam int          CTL_LOW_SPEED   = 11;
   localparam int          CTL_SEL_LSB     = 14;
   localparam logic [31:0] CTL_RW_MASK     = 32'h0000cf0f;
   localparam logic [31:0] CTL_RESET       = 32'h00000000;
   localparam logic [1:0]  PIN_CFG_FORCED  = 2'h1;

   // ---------------------------------------------------------------
   // Debug control and status fields
   // ---------------------------------------------------------------
   localparam int          DC_DBE          = 0;
   localparam int          DC_RES          = 1;
   localparam int          DC_TM_LSB       = 4;
   localparam int          TM_W            = 3;
   localparam int          DC_OVC_LSB      = 8;
   localparam int          OVC_W           = 4;
   localparam logic [31:0] DC_STORE_MASK   = 32'h00000f71;
   localparam logic [31:0] DC_RESET        = 32'h00000000;
   localparam int          ST_CNT_LSB      = 0;
   localparam int          ST_OVR          = 8;
   localparam int          ST_LOST_LSB     = 12;
   localparam int          ST_MSGS_LSB     = 16;

   // ---------------------------------------------------------------
   // Framing, queue and timing
   // ---------------------------------------------------------------
   localparam int          FRAME_W         = 6;
   localparam int          QUEUE_DEPTH     = 16;
   localparam int          PTR_W           = 4;
   localparam int          CNT_W           = 5;
   localparam int          LEN_W           = 6;
   localparam int          ACC_W           = 38;
   localparam int          PKT_BITS        = 32;
   localparam logic [4:0]  Q_FULL_COUNT    = 5'h10;
   localparam logic [4:0]  STALL_ROOM      = 5'h07;
   localparam logic [5:0]  FRAME_BITS      = 6'h06;
   localparam logic [5:0]  LEN_ONE         = 6'h01;
   localparam logic [5:0]  LEN_MAX         = 6'h20;
   localparam logic [4:0]  PERIOD_FULL     = 5'h01;
   localparam logic [4:0]  PERIOD_DIV0     = 5'h02;
   localparam logic [1:0]  MSEO_IDLE       = 2'h3;
   localparam logic [1:0]  MSEO_BODY       = 2'h0;
   localparam logic [1:0]  MSEO_VEND       = 2'h1;

   // ---------------------------------------------------------------
   // Error message
   // ---------------------------------------------------------------
   localparam logic [5:0]  ERR_TCODE       = 6'h08;
   localparam logic [5:0]  TCODE_W         = 6'h06;
   localparam logic [5:0]  ERROR_CODE_PACKET_W         = 6'h05;
   localparam logic [4:0]  ERROR_CODE_PACKET_OWN       = 5'h00;
   localparam logic [4:0]  ERROR_CODE_PACKET_PROG      = 5'h01;
   localparam logic [4:0]  ERROR_CODE_PACKET_DATA      = 5'h02;
   localparam logic [4:0]  ERROR_CODE_PACKET_WATCH     = 5'h06;
   localparam logic [4:0]  ERROR_CODE_PACKET_TRACE     = 5'h07;
   localparam logic [4:0]  ERROR_CODE_PACKET_ALL       = 5'h08;
   localparam logic [1:0]  SRC_OWN         = 2'h0;
   localparam logic [1:0]  SRC_PROG        = 2'h1;
   localparam logic [1:0]  SRC_DATA        = 2'h2;
   localparam logic [1:0]  SRC_WATCH       = 2'h3;

   typedef struct packed {
      logic [31:0] data;
      logic [5:0]  len;
      logic        var_len;
      logic        last;
      logic [1:0]  source;
   } trace_packet_type;

   typedef struct packed {
      logic [5:0] data;
      logic       end_var;
      logic       end_msg;
   } queue_frame_type;

   typedef struct packed {
      logic [5:0] data;
      logic [1:0] mseo;
      logic       oe;
   } aux_pins_type;

   typedef enum logic [0:0] {SER_IDLE = 1'b0, SER_MSG = 1'b1} ser_state_type;
   typedef enum logic [1:0] {ERR_IDLE = 2'b00, ERR_SEND_CODE = 2'b01} err_step_type;

endpackage

/* File: test/trace_aux_sva.sv */
// Checker of the trace port pins, strobes and register echoes
module trace_aux_sva
   import trace_aux_pkg::*;
(
   input wire logic              clk, rst, reg_wr, reg_rd, sync_request_r, trace_enable_r,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [REG_W-1:0]  reg_wdata, reg_rdata_r,
   input wire aux_pins_type      aux_pins_r,
   input wire logic [1:0]        pin_config_r
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic [1:0] se = aux_pins_r.mseo;
   idle_data_a: assert property (se == MSEO_IDLE |-> aux_pins_r.data == '0) else $error("data moves while idle");
   som_mark_a: assert property ($past(se) == MSEO_IDLE && se != MSEO_IDLE |-> se == MSEO_BODY)
      else $error("bad start of message");
   eom_mark_a: assert property ($past(se) != MSEO_IDLE && se == MSEO_IDLE |-> !$past(se[1]))
      else $error("bad end of message");
   evlp_mark_a: assert property ($past(se) != MSEO_VEND && se == MSEO_VEND |-> $past(se) == MSEO_BODY)
      else $error("bad end of variable packet");
   no_ten_a: assert property (se != 2'h2) else $error("illegal start end code");
   sync_pulse_a: assert property (sync_request_r |=> !sync_request_r) else $error("sync longer than one cycle");
   pin_ovr_a: assert property (reg_wr && reg_addr == OFS_PORT_CTRL && reg_wdata[CTL_OVERRIDE]
      |-> ##[1:2] pin_config_r == PIN_CFG_FORCED) else $error("override not applied");
   ctl_echo_a: assert property (reg_wr && reg_addr == OFS_PORT_CTRL ##2 reg_rd && reg_addr == OFS_PORT_CTRL
      |=> reg_rdata_r == ($past(reg_wdata, 3) & CTL_RW_MASK)) else $error("control readback wrong");
   rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata_r == '0) else $error("read data outside slot");
   enable_a: assert property (reg_wr && reg_addr == OFS_DEBUG_CTRL && reg_wdata[DC_DBE]
      |-> ##[1:2] trace_enable_r) else $error("enable not taken");
endmodule
bind trace_aux_port_transmitter trace_aux_sva trace_aux_sva_i (.clk, .rst, .reg_wr, .reg_rd, .sync_request_r,
   .trace_enable_r, .reg_addr, .reg_wdata, .reg_rdata_r, .aux_pins_r, .pin_config_r);

/* File: test/trace_aux_tool.sv */
// Trace capture tool: keeps the first two data frames of the latest message
module trace_aux_tool (
   input wire logic                        msg_clock_o,
   input wire trace_aux_pkg::aux_pins_type aux_pins_r
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] prev = 2'h3;
   logic [5:0] f0 = '0, f1 = '0;
   int         n = 0;
   // Single rate capture on the rising edge; data ignored on idle frames
   always @(posedge msg_clock_o) begin
      if (aux_pins_r.mseo != 2'h3) begin
         if (prev == 2'h3) n = 0;
         if (n == 0) f0 = aux_pins_r.data;
         if (n == 1) f1 = aux_pins_r.data;
         n++;
      end
      prev = aux_pins_r.mseo;
   end
endmodule

/* File: test/trace_aux_port_transmitter_tb.sv */
// Testbench of the trace output port
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("ERROR %0t %h %h", $time, a, b); end end
module trace_aux_port_transmitter_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import trace_aux_pkg::*;
   logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pkt_valid = 0;
   logic pkt_ready_r, cpu_stall_r, sync_request_r, trace_enable_r, msg_clock_o;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [REG_W-1:0]  reg_wdata = '0, reg_rdata_r, rd;
   logic [TM_W-1:0]   trace_mode_r;
   logic [1:0]        pin_config_r;
   trace_packet_type  pkt_in = '0;
   aux_pins_type      aux_pins_r;
   int                fails = 0, check_count = 0, cyc = 0, stalled = 0;
   trace_aux_port_transmitter trace_aux_port_transmitter_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_r, .pkt_valid, .pkt_in, .pkt_ready_r, .cpu_stall_r, .sync_request_r, .trace_enable_r,
      .trace_mode_r, .aux_pins_r, .msg_clock_o, .pin_config_r);
   trace_aux_tool trace_aux_tool_i (.msg_clock_o, .aux_pins_r);
   initial forever #12.5 clk = ~clk;
   // Ceiling well above the few thousand cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cpu_stall_r === 1'b1) stalled++;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end
   task give_verdict;
      $display("fails=%0d check_count=%0d", fails, check_count);
      if (fails == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk); reg_wr <= 0;
   endtask
   task rdr(input logic [7:0] a);
      @(posedge clk); reg_rd <= 1; reg_addr <= a;
      @(posedge clk); reg_rd <= 0;
      @(posedge clk); rd = reg_rdata_r;
   endtask
   // Six-bit program packet; the last one of a message is variable length
   task send(input logic [5:0] d, input logic l);
      @(posedge clk); pkt_valid <= 1; pkt_in <= '{32'(d), 6'h06, l, l, SRC_PROG};
      do @(posedge clk); while (pkt_ready_r !== 1'b1);
      pkt_valid <= 0;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      wr(OFS_PORT_CTRL, 32'hffffffff);
      rdr(OFS_PORT_CTRL); `CHK(rd, CTL_RW_MASK)
      `CHK(pin_config_r, PIN_CFG_FORCED)
      rdr(8'h0c); `CHK(rd, 32'h0)
      wr(OFS_PORT_CTRL, 32'h00000100);
      wr(OFS_DEBUG_CTRL, 32'h00000073);
      rdr(OFS_DEBUG_CTRL); `CHK(rd, 32'h00000071)
      `CHK({trace_enable_r, trace_mode_r, aux_pins_r.oe}, 5'h1f)
      send(6'h04, 0); send(6'h05, 1);
      repeat (40) @(posedge clk);
      `CHK({trace_aux_tool_i.f0, trace_aux_tool_i.f1}, 12'h105)
      // Slow frames so the burst outruns the queue
      wr(OFS_PORT_CTRL, 32'h0000090f);
      repeat (10) begin send(6'h01, 0); send(6'h01, 0); send(6'h01, 0); send(6'h02, 1); end
      rdr(OFS_STATUS); `CHK({rd[ST_OVR], rd[ST_LOST_LSB+:4]}, 5'h12)
      for (int i = 0; i < 3000 && sync_request_r !== 1'b1; i++) @(posedge clk);
      `CHK(sync_request_r, 1'b1)
      repeat (200) @(posedge clk);
      `CHK({trace_aux_tool_i.f0, trace_aux_tool_i.f1}, 12'h201)
      // Program stall bit set: the same burst must stall instead of overrunning
      wr(OFS_DEBUG_CTRL, 32'h00000271);
      repeat (10) begin send(6'h01, 0); send(6'h01, 0); send(6'h01, 0); send(6'h02, 1); end
      rdr(OFS_STATUS); `CHK({rd[ST_OVR], stalled != 0, rd[ST_CNT_LSB+:CNT_W] != 0}, 3'h3)
      wr(OFS_DEBUG_CTRL, 32'h00000073);
      rdr(OFS_STATUS); `CHK(rd, 32'h0)
      give_verdict();
   end
endmodule
